// File: include/mac_event_defs.vh
// constants for the gigabit mac transmit/event/timer block
// assumes inclusion by bare name from core files
`ifndef MAC_EVENT_DEFS_VH
`define MAC_EVENT_DEFS_VH
// register byte offsets (word aligned)
`define OFS_EVENT 6'h00
`define OFS_MASK 6'h04
`define OFS_TRANSMIT_DESCRIPTOR_ACTIVE 6'h08
`define OFS_CTRL 6'h0C
`define OFS_STATUS 6'h10
`define OFS_TIME 6'h14
`define OFS_TCSR0 6'h18
`define OFS_TCCR0 6'h28
// event bit positions
`define EV_TXF 0
`define EV_RXF 1
`define EV_WAKE 2
`define EV_TS0 3
`define EV_DROP 7
`define EV_W 8
// control fields
`define CTRL_PAUSE_EN 0
`define CTRL_PAD_FORCE 1
`define CTRL_PAD_SEL_LSB 4
`define CTRL_PAD_SEL_W 4
// channel control fields
`define CH_MODE_CAPTURE 2'b01
`define CH_MODE_COMPARE 2'b10
// reset values
`define RST_MASK 8'h00
`define RST_CTRL 32'h0000_0000
// throughput limit: 470 Mbps of 1000, 400 measured
`define TPUT_MAX_MBPS 11'h1D6
`define TPUT_SUST_MBPS 11'h190
`define LINE_MBPS 11'h3E8
// status fifo depth, pause threshold, small-frame limit
`define STAT_DEPTH 4
`define PAUSE_LEVEL 3
`define SMALL_FRAME_BYTES 800
`define PAUSE_QUANTA 16'hFFFF
`endif

// File: core/time_channel.v
// one capture/compare channel of the precision-time timer
// assumes evIn already synchronised to clk; tick marks timer clock edges
`timescale 1ns/10ps
`include "mac_event_defs.vh"
module time_channel (
	input wire clk,
	input wire rst_b,
	input wire tick,
	input wire [1:0] mode,
	input wire [31:0] timeNow,
	input wire evIn,
	input wire wrValue,
	input wire [31:0] wrData,
	output reg [31:0] value_q,
	output reg hit_q,
	output reg outLevel_q
);
	reg evPrev_q;
	wire rise;
	assign rise = evIn & ~evPrev_q;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			evPrev_q <= 1'b0;
			value_q <= 32'h0000_0000;
			hit_q <= 1'b0;
			outLevel_q <= 1'b0;
		end else begin
			evPrev_q <= evIn;
			hit_q <= 1'b0;
			if (wrValue) begin
				value_q <= wrData;
			end else if (mode == `CH_MODE_CAPTURE && rise) begin
				value_q <= timeNow;
				hit_q <= 1'b1;
			end
			if (mode == `CH_MODE_COMPARE && tick && timeNow == value_q) begin
				hit_q <= 1'b1;
				outLevel_q <= ~outLevel_q;
			end
		end
	end
endmodule

// File: core/mac_event_logic.v
// gigabit mac transmit activation, event flags, interrupt routing and time
// assumes avalon-mm master on clk; event pins and timer clock pad arrive asynchronous and are synchronised
// Notes on behaviour
// - timer has four channels, each capture or compare against the time counter
// - capture latches the time counter, on a rising edge of the channel event, into channel value
// - channel two event shares timer clock pad, so it never captures
// - ready bit seen clear earlier makes mac clear active bit later
// - descriptor processing restarts only on zero-to-one of active bit
// - transmit-frame flag set when a frame completes
// - all sources ORed to aggregator; only wake line to power controller
// - ordinary rx/tx done never reach the power wake controller
// - any source selectable onto pad; with input forced it wakes system
// - throughput bounded at 470 Mbps, about 400 sustained
// - pause frames emitted when enabled to protect the receive fifo
// - small-frame bursts may overflow status fifo; large frames unaffected
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "mac_event_defs.vh"
module mac_event_logic (
	input wire clk,
	input wire rst_b,
	input wire [5:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output wire waitrequest,
	output reg [1:0] response,
	input wire descriptorReadyBit,
	output reg descFetch_q,
	input wire txFrameDone,
	input wire rxFrameDone,
	input wire [15:0] rxFrameBytes,
	input wire rxStatusPop,
	input wire wakeEvent,
	input wire timerClockPad,
	input wire [3:0] eventPin,
	output wire [3:0] compareOut,
	output reg pauseReq_q,
	output wire [15:0] pauseQuanta,
	output wire irqAggregator,
	output wire irqPowerWake,
	output wire interruptOutPad,
	output wire padInputForce
);
	// ---------------------------------------------------------------
	// synchronisers
	// ---------------------------------------------------------------
	// the timer clock pad and the event pins share one two-stage synchroniser
	reg [4:0] sync1_q;
	reg [4:0] sync2_q;
	reg tclkPrev_q;
	wire tick;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= 5'h00;
			sync2_q <= 5'h00;
			tclkPrev_q <= 1'b0;
		end else begin
			sync1_q <= {timerClockPad, eventPin};
			sync2_q <= sync1_q;
			tclkPrev_q <= sync2_q[4];
		end
	end
	// counter advances on rising edges of the timer clock pad
	assign tick = sync2_q[4] & ~tclkPrev_q;
	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	reg [7:0] event_q;
	reg [7:0] mask_q;
	reg [31:0] ctrl_q;
	reg transmit_descriptor_active_q;
	reg [31:0] time_q;
	reg [1:0] chMode_q [0:3];
	reg wasEmpty_q;
	reg [2:0] statCount_q;
	wire [3:0] chHit;
	wire [31:0] chValue [0:3];
	wire wrEn;
	wire [7:0] evSet;
	reg ackPhase_q;
	// one wait state per access, so registered read data already stand at the accept edge
	assign waitrequest = (read || write) && !ackPhase_q;
	// writes land only at the accept edge, never in the wait cycle
	assign wrEn = write && byteenable[0] && ackPhase_q;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ackPhase_q <= 1'b0;
		end else begin
			ackPhase_q <= (read || write) && !ackPhase_q;
		end
	end
	function is_ofs;
		input [5:0] a;
		input [5:0] o;
		begin
			is_ofs = (a == o);
		end
	endfunction
	// ---------------------------------------------------------------
	// timer channels
	// ---------------------------------------------------------------
	// a bus write to a channel value wins over a capture in the same cycle
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : chan
			// channel two event pin is the timer clock pad, so capture cannot work
			wire evSrc;
			localparam [31:0] VAL_OFS = `OFS_TCCR0 + 4 * g;
			assign evSrc = (g == 1) ? 1'b0 : sync2_q[g];
			time_channel u_ch (
				.clk(clk),
				.rst_b(rst_b),
				.tick(tick),
				.mode(chMode_q[g]),
				.timeNow(time_q),
				.evIn(evSrc),
				.wrValue(wrEn && is_ofs(address, VAL_OFS[5:0])),
				.wrData(writedata),
				.value_q(chValue[g]),
				.hit_q(chHit[g]),
				.outLevel_q(compareOut[g])
			);
		end
	endgenerate
	// ---------------------------------------------------------------
	// line-rate budget
	// ---------------------------------------------------------------
	// fractional divider: 470 enable pulses in every 1000 cycles, so frame
	// continuations never outrun the bound on the combined transfer rate
	reg [9:0] budgetAcc_q;
	wire [10:0] budgetSum;
	wire [10:0] budgetDiff;
	wire budgetTick;
	assign budgetSum = {1'b0, budgetAcc_q} + `TPUT_MAX_MBPS;
	assign budgetDiff = budgetSum - `LINE_MBPS;
	assign budgetTick = budgetSum >= `LINE_MBPS;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			budgetAcc_q <= 10'h000;
		end else begin
			// the remainder stays below 1000, so ten bits always hold it
			budgetAcc_q <= budgetTick ? budgetDiff[9:0] : budgetSum[9:0];
		end
	end
	// ---------------------------------------------------------------
	// transmit activation
	// ---------------------------------------------------------------
	reg contPend_q;
	wire tdarSet;
	assign tdarSet = wrEn && is_ofs(address, `OFS_TRANSMIT_DESCRIPTOR_ACTIVE) && writedata[0];
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			transmit_descriptor_active_q <= 1'b0;
			wasEmpty_q <= 1'b0;
			contPend_q <= 1'b0;
			descFetch_q <= 1'b0;
		end else begin
			descFetch_q <= 1'b0;
			if (tdarSet && !transmit_descriptor_active_q) begin
				// only a real 0-to-1 restarts the fetch
				transmit_descriptor_active_q <= 1'b1;
				wasEmpty_q <= 1'b0;
				contPend_q <= 1'b0;
				descFetch_q <= 1'b1;
			end else if (transmit_descriptor_active_q) begin
				// the next descriptor waits for a budget pulse, three cycles at most
				if (contPend_q && budgetTick) begin
					contPend_q <= 1'b0;
					descFetch_q <= 1'b1;
				end
				if (!descriptorReadyBit)
					wasEmpty_q <= 1'b1;
				// a stale empty sighting still drops active at the next frame end
				if (txFrameDone && (wasEmpty_q || !descriptorReadyBit)) begin
					transmit_descriptor_active_q <= 1'b0;
					contPend_q <= 1'b0;
				end else if (txFrameDone) begin
					contPend_q <= 1'b1;
				end
			end
		end
	end
	// ---------------------------------------------------------------
	// receive status fifo and pause
	// ---------------------------------------------------------------
	wire smallFrame;
	wire statFull;
	assign smallFrame = rxFrameBytes <= `SMALL_FRAME_BYTES;
	assign statFull = statCount_q == `STAT_DEPTH;
	assign pauseQuanta = `PAUSE_QUANTA;
	wire pushStat;
	wire dropStat;
	// large frames leave enough time for the dma to drain status
	assign pushStat = rxFrameDone && smallFrame && !statFull;
	assign dropStat = rxFrameDone && smallFrame && statFull;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			statCount_q <= 3'd0;
			pauseReq_q <= 1'b0;
		end else begin
			if (pushStat && !(rxStatusPop && statCount_q != 3'd0))
				statCount_q <= statCount_q + 3'd1;
			else if (!pushStat && rxStatusPop && statCount_q != 3'd0)
				statCount_q <= statCount_q - 3'd1;
			// pause one slot early so a frame already on the wire still finds room
			pauseReq_q <= ctrl_q[`CTRL_PAUSE_EN] && statCount_q >= `PAUSE_LEVEL;
		end
	end
	// ---------------------------------------------------------------
	// events and interrupts
	// ---------------------------------------------------------------
	assign evSet = {dropStat, chHit, wakeEvent, rxFrameDone, txFrameDone};
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			event_q <= 8'h00;
		end else begin
			// a new event wins over a simultaneous clear
			if (wrEn && is_ofs(address, `OFS_EVENT))
				event_q <= (event_q & ~writedata[7:0]) | evSet;
			else
				event_q <= event_q | evSet;
		end
	end
	wire [7:0] pending;
	wire [3:0] padSel;
	assign pending = event_q & mask_q;
	// selector 8 routes the whole aggregate; 9 to 15 hold the pad low
	assign padSel = ctrl_q[`CTRL_PAD_SEL_LSB +: `CTRL_PAD_SEL_W];
	assign irqAggregator = |pending;
	// rx/tx done deliberately absent from the wake path
	assign irqPowerWake = pending[`EV_WAKE];
	assign interruptOutPad = (padSel == 4'h8) ? irqAggregator :
		((padSel < 4'h8) ? pending[padSel[2:0]] : 1'b0);
	// forcing the pad input on lets the routed interrupt wake the system
	assign padInputForce = ctrl_q[`CTRL_PAD_FORCE];
	// ---------------------------------------------------------------
	// register writes and time counter
	// ---------------------------------------------------------------
	integer i;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mask_q <= `RST_MASK;
			ctrl_q <= `RST_CTRL;
			time_q <= 32'h0000_0000;
			for (i = 0; i < 4; i = i + 1)
				chMode_q[i] <= 2'b00;
		end else begin
			if (tick)
				time_q <= time_q + 32'h0000_0001;
			if (wrEn && is_ofs(address, `OFS_MASK))
				mask_q <= writedata[7:0];
			if (wrEn && is_ofs(address, `OFS_CTRL))
				ctrl_q <= writedata;
			// a time write comes after the tick increment, so software wins
			if (wrEn && is_ofs(address, `OFS_TIME))
				time_q <= writedata;
			for (i = 0; i < 4; i = i + 1)
				if (wrEn && address == (`OFS_TCSR0 + 4 * i))
					chMode_q[i] <= writedata[1:0];
		end
	end
	// ---------------------------------------------------------------
	// register reads
	// ---------------------------------------------------------------
	reg [31:0] rdMux;
	reg rdHit;
	// unmapped offsets read as zero and answer with an error response
	always @* begin
		rdMux = 32'h0000_0000;
		rdHit = 1'b1;
		case (address)
			`OFS_EVENT: rdMux = {24'h00_0000, event_q};
			`OFS_MASK: rdMux = {24'h00_0000, mask_q};
			`OFS_TRANSMIT_DESCRIPTOR_ACTIVE: rdMux = {31'h0000_0000, transmit_descriptor_active_q};
			`OFS_CTRL: rdMux = ctrl_q;
			`OFS_STATUS: rdMux = {27'h000_0000, statCount_q, pauseReq_q, wasEmpty_q};
			`OFS_TIME: rdMux = time_q;
			6'h18: rdMux = {30'h0000_0000, chMode_q[0]};
			6'h1C: rdMux = {30'h0000_0000, chMode_q[1]};
			6'h20: rdMux = {30'h0000_0000, chMode_q[2]};
			6'h24: rdMux = {30'h0000_0000, chMode_q[3]};
			6'h28: rdMux = chValue[0];
			6'h2C: rdMux = chValue[1];
			6'h30: rdMux = chValue[2];
			6'h34: rdMux = chValue[3];
			default: rdHit = 1'b0;
		endcase
	end
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			readdata <= 32'h0000_0000;
			response <= 2'b00;
		end else begin
			readdata <= read ? rdMux : 32'h0000_0000;
			response <= ((read || write) && !rdHit) ? 2'b10 : 2'b00;
		end
	end
endmodule

// File: verification/mac_event_logic_monitor.sv
// port assertions for mac_event_logic
// assumes one clk domain with rst_b async active low
`timescale 1ns/10ps
module mac_event_logic_monitor (
	input wire clk,
	input wire rst_b,
	input wire [5:0] address,
	input wire read,
	input wire write,
	input wire waitrequest,
	input wire [1:0] response,
	input wire rxFrameDone,
	input wire wakeEvent,
	input wire pauseReq_q,
	input wire [15:0] pauseQuanta,
	input wire irqAggregator,
	input wire irqPowerWake,
	input wire padInputForce
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_quanta_fixed: assert property (pauseQuanta == 16'hFFFF)
		else $error("pause quanta wrong");
	a_wake_in_or: assert property (irqPowerWake |-> irqAggregator)
		else $error("wake line outside aggregate");
	a_wake_cause: assert property ($rose(irqPowerWake) |->
		$past(wakeEvent) || $past(write)) else $error("wake line without wake");
	a_force_cause: assert property ($changed(padInputForce) |->
		$past(write && address == 6'h0C)) else $error("pad force moved alone");
	a_pause_cause: assert property ($rose(pauseReq_q) |->
		$past(rxFrameDone, 2) || $past(write, 2)) else $error("pause without frame");
	a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("more than one wait state");
	a_wait_idle: assert property (!(read || write) |-> !waitrequest)
		else $error("wait without request");
	a_unmapped_err: assert property ((read || write) && address == 6'h3C
		|=> response == 2'h2) else $error("unmapped not refused");
	a_mapped_ok: assert property ((read || write) && address == 6'h00
		|=> response == 2'h0) else $error("mapped access refused");
endmodule
bind mac_event_logic mac_event_logic_monitor mon_i (.clk(clk), .rst_b(rst_b),
	.address(address), .read(read), .write(write), .waitrequest(waitrequest),
	.response(response), .rxFrameDone(rxFrameDone), .wakeEvent(wakeEvent),
	.pauseReq_q(pauseReq_q), .pauseQuanta(pauseQuanta), .irqAggregator(irqAggregator),
	.irqPowerWake(irqPowerWake), .padInputForce(padInputForce));

// File: verification/line_partner.sv
// remote station: ends a tx frame txDelay cycles after a fetch, sends rx frames
// assumes fetch pulses from the mac and send requests from the bench
`timescale 1ns/10ps
module line_partner (
	input wire clk,
	input wire rst_b,
	input wire descFetch_q,
	input wire pauseReq_q,
	input wire sendReq,
	input wire [15:0] sendLen,
	input wire [7:0] txDelay,
	output reg txFrameDone,
	output reg rxFrameDone,
	output reg [15:0] rxFrameBytes
);
	reg [7:0] cnt_q;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 8'h00;
			txFrameDone <= 1'b0;
			rxFrameDone <= 1'b0;
			rxFrameBytes <= 16'h0000;
		end else begin
			txFrameDone <= cnt_q == 8'h01;
			if (cnt_q != 8'h00)
				cnt_q <= cnt_q - 8'h01;
			else if (descFetch_q)
				cnt_q <= txDelay;
			// a paused station drops the frame it was asked to send
			rxFrameDone <= sendReq && !pauseReq_q;
			// length is junk outside a frame so a stale value cannot pass
			rxFrameBytes <= sendReq ? sendLen : ~rxFrameBytes;
		end
	end
endmodule

// File: verification/mac_event_logic_tb.sv
// self-checking bench for mac_event_logic with a line partner
// assumes read data and response stand at the edge that ends the wait
`timescale 1ns/10ps
`include "mac_event_defs.vh"
module mac_event_logic_tb;
	reg clk = 1'b0;
	reg rst_b = 1'b0;
	reg [5:0] address = 6'h00;
	reg read = 1'b0;
	reg write = 1'b0;
	reg [31:0] writedata = 32'h0000_0000;
	reg [3:0] byteenable = 4'hF;
	reg descriptorReadyBit = 1'b1;
	reg rxStatusPop = 1'b0;
	reg wakeEvent = 1'b0;
	reg timerClockPad = 1'b0;
	reg [3:0] eventPin = 4'h0;
	reg sendReq = 1'b0;
	reg [15:0] sendLen = 16'h0040;
	reg [7:0] txDelay = 8'h10;
	reg [31:0] seed = 32'h0000_0016;
	reg [31:0] rdv;
	reg [1:0] rsp;
	wire [31:0] readdata;
	wire [1:0] response;
	wire waitrequest, descFetch_q, txFrameDone, rxFrameDone, pauseReq_q;
	wire irqAggregator, irqPowerWake, interruptOutPad, padInputForce;
	wire [3:0] compareOut;
	wire [15:0] rxFrameBytes, pauseQuanta;
	integer fail_count = 0;
	integer comparisons = 0;
	integer fetches = 0;
	integer cyc = 0;
	integer i;
	mac_event_logic mac_event_logic_i (.clk(clk), .rst_b(rst_b), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .response(response),
		.descriptorReadyBit(descriptorReadyBit), .descFetch_q(descFetch_q),
		.txFrameDone(txFrameDone), .rxFrameDone(rxFrameDone),
		.rxFrameBytes(rxFrameBytes), .rxStatusPop(rxStatusPop), .wakeEvent(wakeEvent),
		.timerClockPad(timerClockPad), .eventPin(eventPin), .compareOut(compareOut),
		.pauseReq_q(pauseReq_q), .pauseQuanta(pauseQuanta),
		.irqAggregator(irqAggregator), .irqPowerWake(irqPowerWake),
		.interruptOutPad(interruptOutPad), .padInputForce(padInputForce));
	line_partner line_partner_i (.clk(clk), .rst_b(rst_b), .descFetch_q(descFetch_q),
		.pauseReq_q(pauseReq_q), .sendReq(sendReq), .sendLen(sendLen),
		.txDelay(txDelay), .txFrameDone(txFrameDone), .rxFrameDone(rxFrameDone),
		.rxFrameBytes(rxFrameBytes));
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc % 3 == 0) timerClockPad <= ~timerClockPad;
		if (descFetch_q === 1'b1) fetches <= fetches + 1;
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			end_of_test;
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [31:0] xs(input [31:0] x);
		begin
			x = x ^ (x << 13);
			x = x ^ (x >> 17);
			xs = x ^ (x << 5);
		end
	endfunction
	task chk(input string n, input [31:0] s, input [31:0] e);
		begin
			comparisons = comparisons + 1;
			if (s !== e) begin
				fail_count = fail_count + 1;
				$display("MISMATCH %s expected %h seen %h", n, e, s);
			end
		end
	endtask
	task bus(input r, input [5:0] a, input [31:0] d);
		begin
			address <= a;
			read <= r;
			write <= !r;
			writedata <= d;
			@(posedge clk);
			while (waitrequest !== 1'b0) @(posedge clk);
			// accept edge: the answer is taken before anything is released
			rdv = readdata;
			rsp = response;
			read <= 1'b0;
			write <= 1'b0;
			@(posedge clk);
		end
	endtask
	task send(input [15:0] n);
		begin
			sendLen <= n;
			sendReq <= 1'b1;
			@(posedge clk);
			sendReq <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask
	task end_of_test;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, fail_count);
			if (fail_count == 0 && comparisons > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		bus(1, `OFS_CTRL, 0);
		chk("ctrl", rdv, `RST_CTRL);
		bus(1, 6'h3C, 0);
		chk("unmapped", rsp, 2'h2);
		byteenable <= 4'hE;
		bus(0, `OFS_MASK, 32'h0000_00FF);
		byteenable <= 4'hF;
		bus(1, `OFS_MASK, 0);
		chk("mask", rdv, `RST_MASK);
		bus(0, `OFS_MASK, 32'h0000_00FF);
		$display("test regs done");
		seed = xs(seed);
		txDelay <= 8'h10 + seed[5:0];
		bus(0, `OFS_TRANSMIT_DESCRIPTOR_ACTIVE, 1);
		bus(0, `OFS_TRANSMIT_DESCRIPTOR_ACTIVE, 1);
		chk("fetch", fetches, 1);
		descriptorReadyBit <= 1'b0;
		for (i = 0; i < 200 && txFrameDone !== 1'b1; i = i + 1) @(posedge clk);
		repeat (3) @(posedge clk);
		bus(1, `OFS_TRANSMIT_DESCRIPTOR_ACTIVE, 0);
		chk("active", rdv[0], 0);
		bus(1, `OFS_EVENT, 0);
		chk("txf", rdv[`EV_TXF], 1);
		chk("irq", irqAggregator, 1);
		chk("wake", irqPowerWake, 0);
		bus(0, `OFS_CTRL, 32'h0000_0002);
		chk("force", padInputForce, 1);
		chk("pad", interruptOutPad, 1);
		bus(0, `OFS_EVENT, 1);
		chk("irq clr", irqAggregator, 0);
		descriptorReadyBit <= 1'b1;
		bus(0, `OFS_TRANSMIT_DESCRIPTOR_ACTIVE, 1);
		@(posedge clk);
		chk("refetch", fetches, 2);
		for (i = 0; i < 200 && txFrameDone !== 1'b1; i = i + 1) @(posedge clk);
		repeat (5) @(posedge clk);
		chk("cont", fetches, 3);
		bus(1, `OFS_TRANSMIT_DESCRIPTOR_ACTIVE, 0);
		chk("still active", rdv[0], 1);
		descriptorReadyBit <= 1'b0;
		wakeEvent <= 1'b1;
		@(posedge clk);
		wakeEvent <= 1'b0;
		repeat (2) @(posedge clk);
		chk("wake on", irqPowerWake, 1);
		$display("test events done");
		for (i = 0; i < 4; i = i + 1) begin
			bus(0, `OFS_TCSR0 + 6'h04 * i[5:0], `CH_MODE_COMPARE);
			bus(1, `OFS_TCSR0 + 6'h04 * i[5:0], 0);
			chk("mode", rdv[1:0], `CH_MODE_COMPARE);
		end
		bus(1, `OFS_TIME, 0);
		bus(0, 6'h34, rdv + 32'h0000_0008);
		repeat (100) @(posedge clk);
		chk("cmp", compareOut[3], 1);
		bus(0, `OFS_TCSR0, `CH_MODE_CAPTURE);
		bus(0, 6'h1C, `CH_MODE_CAPTURE);
		eventPin <= 4'h3;
		repeat (20) @(posedge clk);
		eventPin <= 4'h0;
		bus(1, `OFS_TCCR0, 0);
		chk("cap", rdv != 0, 1);
		bus(1, 6'h2C, 0);
		chk("chan2", rdv, 0);
		$display("test timer done");
		bus(0, `OFS_CTRL, 1);
		for (i = 0; i < 4; i = i + 1) begin
			seed = xs(seed);
			send(16'h0321 + seed[10:0]);
		end
		chk("big", pauseReq_q, 0);
		repeat (3) send(16'h0040);
		chk("pause", pauseReq_q, 1);
		$display("test pause done");
		end_of_test;
	end
endmodule
